// File: ccd_map.svh
`ifndef CCD_MAP_SVH
`define CCD_MAP_SVH
// register byte offsets
`define CCD_OFF_CFG_SEL   8'h00
`define CCD_OFF_CFG_DATA  8'h04
`define CCD_OFF_IRQ_STAT  8'h08
`define CCD_OFF_IRQ_MASK  8'h0C
`define CCD_OFF_EVENTS    8'h10
`define CCD_OFF_PAD_COUNT    8'h14
// configuration word field positions
`define CCD_PAD_ADJUST_ENABLE_BIT      31
`define CCD_RSVD_HI_BIT   30
`define CCD_START_HI      29
`define CCD_START_LO      24
`define CCD_INV_BIT       23
`define CCD_RSVD_LO_BIT   22
`define CCD_LEN_HI        21
`define CCD_LEN_LO        16
`define CCD_EOP_BIT       15
`define CCD_PROTO_HI      14
`define CCD_PROTO_LO      12
`define CCD_MAX_LENGTH_SELECT_HI     11
`define CCD_MAX_LENGTH_SELECT_LO     10
`define CCD_FCS_BIT       9
`define CCD_MSK_THR_BIT   8
`define CCD_MSK_INC_BIT   7
`define CCD_MSK_DEC_BIT   6
// reset value and writable-bit mask
`define CCD_CFG_RESET     32'h0000_0000
`define CCD_WRITE_MASK    32'hBFBF_FFC0
// status bit positions and status field width
`define CCD_ST_EOP        0
`define CCD_ST_THR        1
`define CCD_ST_INC        2
`define CCD_ST_DEC        3
`define CCD_ST_BAD_CODE   4
`define CCD_ST_W          5
`endif

// File: ccd_pkg.sv
package ccd_pkg;
	typedef enum logic [2:0] {
		CCD_PROTO_TRANSPARENT = 3'h0,
		CCD_PROTO_SS7_FCS16   = 3'h1,
		CCD_PROTO_HDLC_FCS16  = 3'h2,
		CCD_PROTO_HDLC_FCS32  = 3'h3
	} ccd_proto_t;

	typedef enum logic [1:0] {
		CCD_LEN_NONE = 2'h0,
		CCD_LEN_ONE  = 2'h1,
		CCD_LEN_TWO  = 2'h2
	} ccd_max_length_select_t;

	typedef struct packed {
		logic       pad_adjust_enable;
		logic       rsvd_hi;
		logic [5:0] fifo_start_index;
		logic       data_invert;
		logic       rsvd_lo;
		logic [5:0] fifo_length_code;
		logic       end_of_padfill_irq_enable;
		logic [2:0] protocol;
		logic [1:0] max_length_select;
		logic       fcs_pass_through;
		logic       mask_error_threshold_irq;
		logic       mask_error_increment_irq;
		logic       mask_error_decrement_irq;
		logic [5:0] rsvd_tail;
	} ccd_cfg_t;

	// decoded settings handed to one channel engine
	typedef struct packed {
		logic [5:0]  fifo_base;
		logic [7:0]  fifo_dwords;
		logic        invert;
		logic        length_check;
		logic        use_limit_two;
		logic        append_fcs;
		logic        store_fcs;
		logic        short_check;
		logic        fcs32;
		logic        ss7;
		logic        proto_bad;
	} ccd_dec_t;

	// engine events for the selected channel direction
	typedef struct packed {
		logic padfill_end;
		logic su_err_thr;
		logic su_err_inc;
		logic su_err_dec;
		logic zero_insert;
	} ccd_evt_t;
endpackage

// File: ccd_decode.sv
`timescale 1ns/1ps
`default_nettype none
module ccd_decode (
	// raw word
	input  wire ccd_pkg::ccd_cfg_t cfg,
	// decoded view
	output var  ccd_pkg::ccd_dec_t dec
);
	import ccd_pkg::*;

	always_comb begin
		dec.fifo_base     = cfg.fifo_start_index;
		dec.fifo_dwords   = {1'b0, cfg.fifo_length_code, 1'b0} + 8'h02;
		dec.invert        = cfg.data_invert;
		dec.length_check  = (cfg.max_length_select == CCD_LEN_ONE) ||
			(cfg.max_length_select == CCD_LEN_TWO);
		dec.use_limit_two = (cfg.max_length_select == CCD_LEN_TWO);
		dec.append_fcs    = !cfg.fcs_pass_through;
		dec.store_fcs     = cfg.fcs_pass_through;
		dec.short_check   = !cfg.fcs_pass_through;
		dec.fcs32         = (cfg.protocol == CCD_PROTO_HDLC_FCS32);
		dec.ss7           = (cfg.protocol == CCD_PROTO_SS7_FCS16);
		dec.proto_bad     = cfg.protocol[2] || (cfg.max_length_select == 2'h3);
	end
endmodule
`default_nettype wire

// File: ccd_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccd_map.svh"
module ccd_regs #(
	parameter int CHANNELS = 32,
	parameter int CH_W     = 5
) (
	// clock and reset
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	// axi4-lite write address
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output var  logic                 s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output var  logic                 s_axi_wready,
	// axi4-lite write response
	output var  logic [1:0]           s_axi_bresp,
	output var  logic                 s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	// axi4-lite read address
	input  wire logic [7:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output var  logic                 s_axi_arready,
	// axi4-lite read data
	output var  logic [31:0]          s_axi_rdata,
	output var  logic [1:0]           s_axi_rresp,
	output var  logic                 s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	// engine side: channel-direction being served
	input  wire logic [CH_W-1:0]      eng_channel,
	input  wire logic                 eng_is_rx,
	input  wire ccd_pkg::ccd_evt_t    eng_evt,
	input  wire logic [7:0]           eng_tx_data,
	input  wire logic [7:0]           eng_rx_data,
	// engine side: decoded configuration and data, plus the interrupt output
	output var  ccd_pkg::ccd_dec_t    eng_cfg,
	output var  logic [7:0]           eng_tx_line,
	output var  logic [7:0]           eng_rx_mem,
	output var  logic                 irq
);
	import ccd_pkg::*;

	localparam int SLOTS = 2 * CHANNELS;

	typedef struct packed {
		logic          aw_got;
		logic [7:0]    aw_addr;
		logic          w_got;
		logic [31:0]   w_data;
		logic [3:0]    w_strb;
		logic          bvalid;
		logic [1:0]    bresp;
		logic          rvalid;
		logic [1:0]    rresp;
		logic [31:0]   rdata;
		logic [CH_W:0] sel;
		logic [`CCD_ST_W-1:0] stat;
		logic [`CCD_ST_W-1:0] mask;
		logic [7:0]    pad_count;
		ccd_dec_t      dec;
		logic [7:0]    tx_line;
		logic [7:0]    rx_mem;
		logic          irq;
	} ccd_state_t;

	ccd_state_t s_q, s_d;
	logic [31:0] cfg_mem [SLOTS];
	logic        cfg_we;
	logic [31:0] cfg_wval;
	logic [31:0] cfg_sel_word;
	ccd_cfg_t    cfg_eng;
	ccd_dec_t    dec_eng;
	logic [`CCD_ST_W-1:0] ev;
	logic        do_write;
	logic [31:0] wmask;

	////////////////////////////////////////////////////////////////
	// per channel-direction configuration store
	// cleared on reset so an unwritten slot never decodes unknown
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < SLOTS; i++) begin
				cfg_mem[i] <= `CCD_CFG_RESET;
			end
		end else if (cfg_we) begin
			cfg_mem[s_q.sel] <= cfg_wval;
		end
	end

	assign cfg_sel_word = cfg_mem[s_q.sel];
	assign cfg_eng      = ccd_cfg_t'(cfg_mem[{eng_is_rx, eng_channel}]);

	ccd_decode u_decode (
		.cfg (cfg_eng),
		.dec (dec_eng)
	);

	////////////////////////////////////////////////////////////////
	// event qualification
	always_comb begin
		ev = '0;
		ev[`CCD_ST_EOP] = eng_evt.padfill_end && !eng_is_rx &&
			cfg_eng.end_of_padfill_irq_enable;
		ev[`CCD_ST_THR] = eng_evt.su_err_thr && eng_is_rx && dec_eng.ss7 &&
			!cfg_eng.mask_error_threshold_irq;
		ev[`CCD_ST_INC] = eng_evt.su_err_inc && eng_is_rx && dec_eng.ss7 &&
			!cfg_eng.mask_error_increment_irq;
		ev[`CCD_ST_DEC] = eng_evt.su_err_dec && eng_is_rx && dec_eng.ss7 &&
			!cfg_eng.mask_error_decrement_irq;
		ev[`CCD_ST_BAD_CODE] = dec_eng.proto_bad;
	end

	for (genvar b = 0; b < 4; b++) begin : g_mask
		assign wmask[8*b +: 8] = {8{s_q.w_strb[b]}};
	end

	assign do_write = s_q.aw_got && s_q.w_got && !s_q.bvalid;

	////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		s_d      = s_q;
		cfg_we   = 1'b0;
		cfg_wval = (cfg_sel_word & ~wmask) | (s_q.w_data & wmask & `CCD_WRITE_MASK);
		if (s_axi_awvalid && !s_q.aw_got) begin
			s_d.aw_got  = 1'b1;
			s_d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_q.w_got) begin
			s_d.w_got  = 1'b1;
			s_d.w_data = s_axi_wdata;
			s_d.w_strb = s_axi_wstrb;
		end
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end
		s_d.stat = s_q.stat;
		if (do_write) begin
			s_d.aw_got = 1'b0;
			s_d.w_got  = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp  = 2'h0;
			unique case (s_q.aw_addr)
				`CCD_OFF_CFG_SEL: begin
					if (s_q.w_strb[0]) begin
						s_d.sel = s_q.w_data[CH_W:0];
					end
				end
				`CCD_OFF_CFG_DATA: cfg_we = 1'b1;
				`CCD_OFF_IRQ_STAT: begin
					if (s_q.w_strb[0]) begin
						s_d.stat = s_q.stat & ~s_q.w_data[`CCD_ST_W-1:0];
					end
				end
				`CCD_OFF_IRQ_MASK: begin
					if (s_q.w_strb[0]) begin
						s_d.mask = s_q.w_data[`CCD_ST_W-1:0];
					end
				end
				`CCD_OFF_PAD_COUNT: begin
					if (s_q.w_strb[0]) begin
						s_d.pad_count = s_q.w_data[7:0];
					end
				end
				default: s_d.bresp = 2'h2;
			endcase
		end
		s_d.stat = s_d.stat | ev;
		// pad count shrinks on zero insertion
		if (eng_evt.zero_insert && !eng_is_rx && cfg_eng.pad_adjust_enable &&
			s_d.pad_count != 8'h00) begin
			s_d.pad_count = s_d.pad_count - 8'h01;
		end
		if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !s_q.rvalid) begin
			s_d.rvalid = 1'b1;
			s_d.rresp  = 2'h0;
			s_d.rdata  = 32'h0000_0000;
			unique case (s_axi_araddr)
				`CCD_OFF_CFG_SEL:  s_d.rdata = 32'(s_q.sel);
				`CCD_OFF_CFG_DATA: s_d.rdata = cfg_sel_word;
				`CCD_OFF_IRQ_STAT: s_d.rdata = 32'(s_q.stat);
				`CCD_OFF_IRQ_MASK: s_d.rdata = 32'(s_q.mask);
				`CCD_OFF_EVENTS:   s_d.rdata = 32'(s_q.stat & s_q.mask);
				`CCD_OFF_PAD_COUNT:   s_d.rdata = 32'(s_q.pad_count);
				default:           s_d.rresp = 2'h2;
			endcase
		end
		s_d.dec     = dec_eng;
		s_d.tx_line = dec_eng.invert ? ~eng_tx_data : eng_tx_data;
		s_d.rx_mem  = dec_eng.invert ? ~eng_rx_data : eng_rx_data;
		s_d.irq     = |(s_d.stat & s_d.mask);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs
	assign s_axi_awready = !s_q.aw_got;
	assign s_axi_wready  = !s_q.w_got;
	assign s_axi_bvalid  = s_q.bvalid;
	assign s_axi_bresp   = s_q.bresp;
	assign s_axi_arready = !s_q.rvalid;
	assign s_axi_rvalid  = s_q.rvalid;
	assign s_axi_rresp   = s_q.rresp;
	assign s_axi_rdata   = s_q.rdata;
	assign eng_cfg       = s_q.dec;
	assign eng_tx_line   = s_q.tx_line;
	assign eng_rx_mem    = s_q.rx_mem;
	assign irq           = s_q.irq;
endmodule
`default_nettype wire

// File: ccd_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ccd_regs_chk (
	// clock and reset
	input wire logic              aclk,
	input wire logic              aresetn,
	// bus handshakes
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready,
	// engine side
	input wire ccd_pkg::ccd_dec_t eng_cfg,
	input wire logic [7:0]        eng_tx_data,
	input wire logic [7:0]        eng_rx_data,
	input wire logic [7:0]        eng_tx_line,
	input wire logic [7:0]        eng_rx_mem
);
	import ccd_pkg::*;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read data dropped early");
	a_tx_inv: assert property ($past(aresetn) && $stable(eng_cfg) |->
		eng_tx_line == ($past(eng_tx_data) ^ {8{eng_cfg.invert}})) else $error("tx data bad");
	a_rx_inv: assert property ($past(aresetn) && $stable(eng_cfg) |->
		eng_rx_mem == ($past(eng_rx_data) ^ {8{eng_cfg.invert}})) else $error("rx data bad");
	a_fifo_size: assert property (eng_cfg.fifo_dwords != 8'h00 |->
		!eng_cfg.fifo_dwords[0] && eng_cfg.fifo_dwords <= 8'h80) else $error("fifo size bad");
	a_pass_short: assert property (eng_cfg.store_fcs |-> !eng_cfg.short_check)
		else $error("short check in pass-through");
	a_ss7_fcs: assert property (eng_cfg.ss7 |-> !eng_cfg.fcs32)
		else $error("ss7 with long fcs");
	a_len_two: assert property (eng_cfg.use_limit_two |-> eng_cfg.length_check)
		else $error("limit two without check");
endmodule
bind ccd_regs ccd_regs_chk ccd_regs_chk_i (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
	.s_axi_rvalid, .s_axi_rready, .eng_cfg, .eng_tx_data, .eng_rx_data, .eng_tx_line, .eng_rx_mem);
`default_nettype wire

// File: ccd_host.sv
`timescale 1ns/1ps
`default_nettype none
module ccd_host (
	// clock
	input  wire logic        aclk,
	// write side
	output var  logic [7:0]  s_axi_awaddr,
	output var  logic        s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output var  logic [31:0] s_axi_wdata,
	output var  logic [3:0]  s_axi_wstrb,
	output var  logic        s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	output var  logic        s_axi_bready,
	// read side
	output var  logic [7:0]  s_axi_araddr,
	output var  logic        s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output var  logic        s_axi_rready
);
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d & 32'hBFBF_FFFF;
		s_axi_wstrb <= 4'hF;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge aclk);
			if (s_axi_awready) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
			if (s_axi_wready) {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge aclk);
			if (s_axi_arready) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
		end while (!s_axi_rvalid);
		{d, r} = {s_axi_rdata, s_axi_rresp};
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask
endmodule
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccd_map.svh"
module testbench;
	import ccd_pkg::*;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, eng_is_rx, irq;
	logic [7:0] s_axi_awaddr, s_axi_araddr, eng_tx_data, eng_rx_data, eng_tx_line, eng_rx_mem;
	logic [31:0] s_axi_wdata, s_axi_rdata, rv;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	logic [3:0] s_axi_wstrb;
	logic [4:0] eng_channel;
	ccd_evt_t eng_evt;
	ccd_dec_t eng_cfg;
	int failures, n_tests;
	initial begin
		aclk = 0;
		forever #20 aclk = ~aclk;
	end
	ccd_regs ccd_regs_i (.*);
	ccd_host ccd_host_i (.*);
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic cfg(input logic [5:0] slot, input logic [31:0] w);
		ccd_host_i.wr(`CCD_OFF_CFG_SEL, {26'h0, slot}, rr);
		ccd_host_i.wr(`CCD_OFF_CFG_DATA, w, rr);
	endtask
	task automatic serve(input logic [4:0] ch, input logic rx);
		{eng_channel, eng_is_rx} <= {ch, rx};
		repeat (3) @(posedge aclk);
	endtask
	task automatic pulse(input ccd_evt_t e);
		eng_evt <= e;
		@(posedge aclk);
		eng_evt <= '0;
		repeat (4) @(posedge aclk);
	endtask
	task automatic t_slots();
		cfg(6'h03, 32'h2A3F_3800);
		cfg(6'h23, 32'h0500_1200);
		ccd_host_i.rd(`CCD_OFF_CFG_DATA, rv, rr);
		chk("cfg word", 32'h0500_1200, rv);
		serve(5'd3, 1'b0);
		chk("tx dec", 32'h0002_A80F, 32'({eng_cfg.fifo_base, eng_cfg.fifo_dwords,
			eng_cfg.fcs32, eng_cfg.use_limit_two, eng_cfg.length_check, eng_cfg.append_fcs}));
		serve(5'd3, 1'b1);
		chk("rx dec", 32'h0000_502C, 32'({eng_cfg.fifo_base, eng_cfg.fifo_dwords,
			eng_cfg.ss7, eng_cfg.store_fcs, eng_cfg.short_check, eng_cfg.length_check}));
		ccd_host_i.rd(8'h18, rv, rr);
		chk("bad read", 32'h2, 32'(rr));
		chk("bad rdata", 32'h0, rv);
		ccd_host_i.wr(8'h1C, 32'h1, rr);
		chk("bad write", 32'h2, 32'(rr));
		$display("t_slots done");
	endtask
	task automatic t_inv();
		cfg(6'h01, 32'h0080_0000);
		cfg(6'h21, 32'h0000_0000);
		{eng_tx_data, eng_rx_data} <= 16'h5A3C;
		serve(5'd1, 1'b0);
		chk("tx line", 32'hA5, 32'(eng_tx_line));
		serve(5'd1, 1'b1);
		chk("rx mem", 32'h3C, 32'(eng_rx_mem));
		$display("t_inv done");
	endtask
	task automatic t_irq();
		ccd_host_i.wr(`CCD_OFF_IRQ_MASK, 32'h0F, rr);
		cfg(6'h02, 32'h0000_8000);
		cfg(6'h22, 32'h0000_1080);
		serve(5'd2, 1'b0);
		pulse(5'b10000);
		chk("irq eop", 32'h1, 32'(irq));
		ccd_host_i.wr(`CCD_OFF_IRQ_STAT, 32'h1, rr);
		repeat (3) @(posedge aclk);
		chk("irq clr", 32'h0, 32'(irq));
		serve(5'd2, 1'b1);
		pulse(5'b00100);
		chk("irq masked", 32'h0, 32'(irq));
		pulse(5'b01010);
		ccd_host_i.rd(`CCD_OFF_IRQ_STAT, rv, rr);
		chk("stat", 32'hA, rv);
		ccd_host_i.rd(`CCD_OFF_EVENTS, rv, rr);
		chk("events", 32'hA, rv);
		ccd_host_i.wr(`CCD_OFF_IRQ_STAT, 32'hA, rr);
		$display("t_irq done");
	endtask
	task automatic t_pad();
		ccd_host_i.wr(`CCD_OFF_PAD_COUNT, 32'h5, rr);
		cfg(6'h04, 32'h8000_0000);
		serve(5'd4, 1'b0);
		pulse(5'b00001);
		ccd_host_i.rd(`CCD_OFF_PAD_COUNT, rv, rr);
		chk("pad on", 32'h4, rv);
		cfg(6'h04, 32'h0000_0000);
		pulse(5'b00001);
		ccd_host_i.rd(`CCD_OFF_PAD_COUNT, rv, rr);
		chk("pad off", 32'h4, rv);
		$display("t_pad done");
	endtask
	initial begin
		{aresetn, eng_is_rx, eng_channel, eng_tx_data, eng_rx_data, eng_evt} = '0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_slots();
		t_inv();
		t_irq();
		t_pad();
		stop_test();
	end
	initial begin
		repeat (5000) @(posedge aclk);
		failures++;
		stop_test();
	end
endmodule
`default_nettype wire
